// ==== logic/ehl_error_history_log.v ====
// Error history log: ten-entry snapshot store with sequential readout
`timescale 1ns/10ps
`default_nettype none
`include "ehl_map.vh"
module ehl_error_history_log
(
  input  wire        clk_i,
  input  wire        reset_n_i,
  // Parameter access port
  input  wire        par_rd_i,
  input  wire        par_wr_i,
  input  wire [15:0] par_addr_i,
  input  wire [31:0] par_wdata_i,
  output reg  [31:0] par_rdata_o,
  output reg         par_ack_o,
  output reg         par_err_o,
  // Error detection event and live conditions
  input  wire        err_log_i,
  input  wire [15:0] err_code_i,
  input  wire [2:0]  err_class_i,
  input  wire [15:0] err_qual_i,
  input  wire [31:0] op_seconds_i,
  input  wire [15:0] motor_current_i,
  input  wire [15:0] bus_voltage_i,
  input  wire [15:0] velocity_i,
  input  wire [15:0] stage_temp_i,
  input  wire [15:0] device_temp_i,
  input  wire [15:0] enable_cycles_i,
  input  wire [15:0] enable_elapsed_i,
  input  wire [31:0] power_on_count_i
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_CLEAR = 1'b1;

  // Entry rows and fill count keep their value over reset
  reg  [`EHL_ENTRY_W-1:0] mem [0:9];
  reg  [`EHL_PTR_W-1:0]   count_reg;
  reg  [`EHL_PTR_W-1:0]   count_next;
  // Sequential readout
  reg  [`EHL_ENTRY_W-1:0] hold_reg;
  reg  [`EHL_ENTRY_W-1:0] hold_next;
  reg  [`EHL_PTR_W-1:0]   rptr_reg;
  reg  [`EHL_PTR_W-1:0]   rptr_next;
  // Clear sequence
  reg  [`EHL_PTR_W-1:0]   clr_idx_reg;
  reg  [`EHL_PTR_W-1:0]   clr_idx_next;
  reg                     state_reg;
  reg                     state_next;
  // Live power-on count
  reg  [31:0]             pwr_reg;
  // Snapshot and per-row next values
  reg  [`EHL_ENTRY_W-1:0] snap;
  wire [`EHL_ENTRY_W-1:0] row_next [0:9];
  wire [9:0]              row_clr;
  wire [9:0]              row_app;
  // Saturated snapshot fields
  wire [15:0]             class_sat;
  wire [31:0]             time_sat;
  // Decoded requests and status
  wire                    idle;
  wire                    full;
  wire                    has_entry;
  wire                    log_en;
  wire                    rd_code;
  wire                    wr_clear;
  wire                    wr_rewind;
  integer                 i;
  genvar                  j;

  // Zero-extended 16-bit field of a packed entry
  function [31:0] fld16;
    input [`EHL_ENTRY_W-1:0] e;
    input integer            lsb;
    begin
      fld16 = {16'h0000, e[lsb +: 16]};
    end
  endfunction

  // Offset match shared by all request decodes
  function addr_hit;
    input [15:0] addr;
    input [15:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // Offsets that accept a write
  function ofs_writable;
    input [15:0] addr;
    begin
      ofs_writable = addr_hit(addr, `EHL_OFS_HISTORY_CLEAR)
                     || addr_hit(addr, `EHL_OFS_READ_POINTER_REWIND);
    end
  endfunction

  // Control value one in the low half of the write data
  function is_one;
    input [31:0] wdata;
    begin
      is_one = (wdata[15:0] == `EHL_ONE);
    end
  endfunction

  assign idle      = (state_reg == ST_IDLE);
  assign full      = (count_reg == `EHL_DEPTH);
  assign has_entry = idle && (rptr_reg < count_reg);
  assign log_en    = err_log_i && idle && !wr_clear;
  assign rd_code   = par_rd_i
                     && addr_hit(par_addr_i, `EHL_OFS_ENTRY_CODE);
  assign wr_clear  = par_wr_i
                     && addr_hit(par_addr_i, `EHL_OFS_HISTORY_CLEAR)
                     && is_one(par_wdata_i);
  assign wr_rewind = par_wr_i
                     && addr_hit(par_addr_i, `EHL_OFS_READ_POINTER_REWIND)
                     && is_one(par_wdata_i);

  // Class and time saturate before entering the snapshot
  assign class_sat = (err_class_i > 3'h4) ? `EHL_CLASS_MAX
                     : {13'h0000, err_class_i};
  assign time_sat  = (op_seconds_i > `EHL_TIME_MAX) ? `EHL_TIME_MAX
                     : op_seconds_i;

  // Snapshot of live conditions at the detection edge
  always @*
  begin
    snap = {`EHL_ENTRY_W{1'b0}};
    snap[`EHL_F_CODE   +: 16] = err_code_i;
    snap[`EHL_F_CLASS  +: 16] = class_sat;
    snap[`EHL_F_TIME   +: 32] = time_sat;
    snap[`EHL_F_QUAL   +: 16] = err_qual_i;
    snap[`EHL_F_ENCYC  +: 16] = enable_cycles_i;
    snap[`EHL_F_ENTIME +: 16] = enable_elapsed_i;
    snap[`EHL_F_UDC    +: 16] = bus_voltage_i;
    snap[`EHL_F_VEL    +: 16] = velocity_i;
    snap[`EHL_F_CUR    +: 16] = motor_current_i;
    snap[`EHL_F_TPA    +: 16] = stage_temp_i;
    snap[`EHL_F_TDEV   +: 16] = device_temp_i;
  end

  // Next content of each row: clear, shift out oldest, or append
  generate
    for (j = 0; j < 10; j = j + 1)
    begin : g_row
      assign row_clr[j] = !idle
                          && ({28'h000_0000, clr_idx_reg} == j);
      assign row_app[j] = log_en
                          && ({28'h000_0000, count_reg} == j);
      if (j == 9)
      begin : g_last
        // Newest row takes the snapshot when full
        assign row_next[j] =
          row_clr[j] ? {`EHL_ENTRY_W{1'b0}} :
          (row_app[j] || (log_en && full)) ? snap :
          mem[j];
      end
      else
      begin : g_mid
        // Lower rows move down one place when full
        assign row_next[j] =
          row_clr[j] ? {`EHL_ENTRY_W{1'b0}} :
          (log_en && full) ? mem[j+1] :
          row_app[j] ? snap :
          mem[j];
      end
    end
  endgenerate

  // Rows and count have no reset, like non-volatile storage
  always @(posedge clk_i)
  begin
    for (i = 0; i < 10; i = i + 1)
      mem[i] <= row_next[i];
    count_reg <= count_next;
  end

  // Next count, pointer, holding buffer and clear step
  always @*
  begin
    count_next   = count_reg;
    rptr_next    = rptr_reg;
    hold_next    = hold_reg;
    clr_idx_next = clr_idx_reg;
    state_next   = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (wr_clear)
        begin
          state_next   = ST_CLEAR;
          clr_idx_next = 4'h0;
        end
        else
        begin
          if (log_en && !full)
            count_next = count_reg + 4'h1;
          if (wr_rewind)
            rptr_next = 4'h0;
          else if (rd_code)
          begin
            if (has_entry)
            begin
              hold_next = mem[rptr_reg];
              rptr_next = rptr_reg + 4'h1;
            end
            else
              hold_next = {`EHL_ENTRY_W{1'b0}};
          end
        end
      end
      ST_CLEAR:
      begin
        if (clr_idx_reg == `EHL_DEPTH_M1)
        begin
          state_next = ST_IDLE;
          count_next = 4'h0;
          rptr_next  = 4'h0;
          hold_next  = {`EHL_ENTRY_W{1'b0}};
        end
        else
          clr_idx_next = clr_idx_reg + 4'h1;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Readout and clear registers, reset to a rewound view

  // Read pointer
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rptr_reg <= 4'h0;
    end
    else
    begin
      rptr_reg <= rptr_next;
    end
  end

  // Clear step index
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      clr_idx_reg <= 4'h0;
    end
    else
    begin
      clr_idx_reg <= clr_idx_next;
    end
  end

  // Clear state
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Holding buffer
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hold_reg <= {`EHL_ENTRY_W{1'b0}};
    end
    else
    begin
      hold_reg <= hold_next;
    end
  end

  // Power-on count
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pwr_reg <= 32'h0000_0000;
    end
    else
    begin
      pwr_reg <= power_on_count_i;
    end
  end

  // Read data and acknowledge, one cycle after the request
  always @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      par_rdata_o <= 32'h0000_0000;
      par_ack_o   <= 1'b0;
      par_err_o   <= 1'b0;
    end
    else
    begin
      par_ack_o   <= par_rd_i | par_wr_i;
      par_err_o   <= 1'b0;
      par_rdata_o <= 32'h0000_0000;
      if (par_rd_i)
      begin
        case (par_addr_i)
          `EHL_OFS_POWER_ON_COUNT:
            par_rdata_o <= pwr_reg;
          `EHL_OFS_HISTORY_CLEAR:
            par_rdata_o <= {31'h0000_0000, state_reg};
          `EHL_OFS_READ_POINTER_REWIND:
            par_rdata_o <= 32'h0000_0000;
          `EHL_OFS_ENTRY_CODE:
            par_rdata_o <= has_entry
                           ? fld16(mem[rptr_reg], `EHL_F_CODE)
                           : 32'h0000_0000;
          `EHL_OFS_ENTRY_CLASS:
            par_rdata_o <= fld16(hold_reg, `EHL_F_CLASS);
          `EHL_OFS_ENTRY_TIME:
            par_rdata_o <= hold_reg[`EHL_F_TIME +: 32];
          `EHL_OFS_ENTRY_QUALIFIER:
            par_rdata_o <= fld16(hold_reg, `EHL_F_QUAL);
          `EHL_OFS_ENTRY_ENABLE_CYCLES:
            par_rdata_o <= fld16(hold_reg, `EHL_F_ENCYC);
          `EHL_OFS_ENTRY_ENABLE_ELAPSED:
            par_rdata_o <= fld16(hold_reg, `EHL_F_ENTIME);
          `EHL_OFS_ENTRY_BUS_VOLTAGE:
            par_rdata_o <= fld16(hold_reg, `EHL_F_UDC);
          `EHL_OFS_ENTRY_VELOCITY:
            par_rdata_o <= fld16(hold_reg, `EHL_F_VEL);
          `EHL_OFS_ENTRY_MOTOR_CURRENT:
            par_rdata_o <= fld16(hold_reg, `EHL_F_CUR);
          `EHL_OFS_ENTRY_STAGE_TEMP:
            par_rdata_o <= fld16(hold_reg, `EHL_F_TPA);
          `EHL_OFS_ENTRY_DEVICE_TEMP:
            par_rdata_o <= fld16(hold_reg, `EHL_F_TDEV);
          default:
            par_err_o <= 1'b1;
        endcase
      end
      else if (par_wr_i)
      begin
        if (!ofs_writable(par_addr_i))
          par_err_o <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/ehl_map.vh ====
// Register offsets, field layouts and constants of the error history log
`ifndef EHL_MAP_VH
`define EHL_MAP_VH
`define EHL_OFS_POWER_ON_COUNT       16'h3b04
`define EHL_OFS_HISTORY_CLEAR        16'h3b08
`define EHL_OFS_READ_POINTER_REWIND  16'h3b0a
`define EHL_OFS_ENTRY_CODE           16'h3c02
`define EHL_OFS_ENTRY_CLASS          16'h3c04
`define EHL_OFS_ENTRY_TIME           16'h3c06
`define EHL_OFS_ENTRY_QUALIFIER      16'h3c08
`define EHL_OFS_ENTRY_ENABLE_CYCLES  16'h3c0a
`define EHL_OFS_ENTRY_ENABLE_ELAPSED 16'h3c0c
`define EHL_OFS_ENTRY_BUS_VOLTAGE    16'h3c0e
`define EHL_OFS_ENTRY_VELOCITY       16'h3c10
`define EHL_OFS_ENTRY_MOTOR_CURRENT  16'h3c12
`define EHL_OFS_ENTRY_STAGE_TEMP     16'h3c14
`define EHL_OFS_ENTRY_DEVICE_TEMP    16'h3c16
`define EHL_DEPTH                    4'h000a
`define EHL_DEPTH_M1                 4'h0009
`define EHL_PTR_W                    4
`define EHL_ENTRY_W                  208
`define EHL_TIME_MAX                 32'h1fff_ffff
`define EHL_CLASS_MAX                16'h0004
// Entry field positions: lsb of each field in the packed entry
`define EHL_F_CODE                   0
`define EHL_F_CLASS                  16
`define EHL_F_TIME                   32
`define EHL_F_QUAL                   64
`define EHL_F_ENCYC                  80
`define EHL_F_ENTIME                 96
`define EHL_F_UDC                    112
`define EHL_F_VEL                    128
`define EHL_F_CUR                    144
`define EHL_F_TPA                    160
`define EHL_F_TDEV                   176
`define EHL_F_SPARE                  192
`define EHL_ONE                      16'h0001
`define EHL_ZERO16                   16'h0000
`endif

// ==== sim/ehl_error_history_log_properties.sv ====
// Port checks of the error history log
`timescale 1ns/10ps
`default_nettype none
`include "ehl_map.vh"
module ehl_props
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        par_rd_i,
  input wire logic        par_wr_i,
  input wire logic [15:0] par_addr_i,
  input wire logic [31:0] par_wdata_i,
  input wire logic [31:0] par_rdata_o,
  input wire logic        par_ack_o,
  input wire logic        par_err_o,
  input wire logic        err_log_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic rd_code = par_rd_i && par_addr_i == `EHL_OFS_ENTRY_CODE;
  wire logic clr_one = par_wr_i && par_addr_i == `EHL_OFS_HISTORY_CLEAR
                       && par_wdata_i[15:0] == 16'h0001;
  a_ack_follows_req: assert property
    ((par_rd_i || par_wr_i) |=> par_ack_o) else $error("ack missing");
  a_ack_has_cause: assert property
    (par_ack_o |-> $past(par_rd_i || par_wr_i)) else $error("stray ack");
  a_ro_write_err: assert property
    (par_wr_i && par_addr_i == `EHL_OFS_ENTRY_CODE |=> par_err_o && par_ack_o)
    else $error("code write accepted");
  a_class_in_range: assert property
    (par_rd_i && par_addr_i == `EHL_OFS_ENTRY_CLASS |=> par_rdata_o <= 4)
    else $error("class above four");
  a_time_in_range: assert property
    (par_rd_i && par_addr_i == `EHL_OFS_ENTRY_TIME
     |=> par_rdata_o <= 32'h1fff_ffff) else $error("time above limit");
  a_current_upper_zero: assert property
    (par_rd_i && par_addr_i == `EHL_OFS_ENTRY_MOTOR_CURRENT
     |=> par_rdata_o[31:16] == 16'h0000) else $error("current too wide");
  a_rewind_reads_zero: assert property
    (par_rd_i && par_addr_i == `EHL_OFS_READ_POINTER_REWIND
     |=> par_rdata_o == 32'h0000_0000) else $error("rewind reads nonzero");
  a_clear_code_zero: assert property
    (clr_one ##2 rd_code |=> par_rdata_o == 32'h0000_0000)
    else $error("code during clear");
  a_clear_reads_busy: assert property
    (clr_one ##4 par_rd_i && par_addr_i == `EHL_OFS_HISTORY_CLEAR
     |=> par_rdata_o == 32'h0000_0001) else $error("clear not busy");
  cover property (rd_code ##1 par_rdata_o != 32'h0000_0000);
  cover property (err_log_i);
  cover property (par_err_o);
endmodule
bind ehl_error_history_log ehl_props chk_u
(
  .clk_i(clk_i), .reset_n_i(reset_n_i), .par_rd_i(par_rd_i),
  .par_wr_i(par_wr_i), .par_addr_i(par_addr_i), .par_wdata_i(par_wdata_i),
  .par_rdata_o(par_rdata_o), .par_ack_o(par_ack_o), .par_err_o(par_err_o),
  .err_log_i(err_log_i)
);
`default_nettype wire

// ==== sim/ehl_master.sv ====
// Fieldbus master model issuing parameter accesses
`timescale 1ns/10ps
`default_nettype none
module ehl_master
(
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        err_i,
  output var  logic        rd_o,
  output var  logic        wr_o,
  output var  logic [15:0] addr_o,
  output var  logic [31:0] wdata_o
);
  logic [31:0] q;
  logic        e;
  initial
  begin
    rd_o = 0;
    wr_o = 0;
    addr_o = 16'h0000;
    wdata_o = 32'h0000_0000;
  end
  // One pulse per access, answer taken at the acking edge
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    #1;
    rd_o = !w;
    wr_o = w;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    q = rdata_i;
    e = err_i;
    rd_o = 0;
    wr_o = 0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_error_history_log.sv ====
// Self-checking bench for the error history log
`timescale 1ns/10ps
`default_nettype none
`include "ehl_map.vh"
module tb_error_history_log;
  logic        clk_i = 0, reset_n_i = 0, err_log = 0;
  logic        rd, wr, ack, err;
  logic [15:0] addr, code = 16'h0000;
  logic [31:0] wdata, rdata, tsec = 32'h0000_0000;
  logic [2:0]  cls = 3'h0;
  logic [15:0] f [1:8] = '{default: 16'h0000};
  int          mismatches = 0, compares = 0, cyc = 0;
  always #50 clk_i = ~clk_i;
  ehl_error_history_log dut_u
  (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .par_rd_i(rd), .par_wr_i(wr),
    .par_addr_i(addr), .par_wdata_i(wdata), .par_rdata_o(rdata),
    .par_ack_o(ack), .par_err_o(err), .err_log_i(err_log),
    .err_code_i(code), .err_class_i(cls), .err_qual_i(f[1]),
    .op_seconds_i(tsec), .enable_cycles_i(f[2]), .enable_elapsed_i(f[3]),
    .bus_voltage_i(f[4]), .velocity_i(f[5]), .motor_current_i(f[6]),
    .stage_temp_i(f[7]), .device_temp_i(f[8]),
    .power_on_count_i(32'h8765_4321)
  );
  ehl_master mst
  (
    .clk_i(clk_i), .rdata_i(rdata), .err_i(err), .rd_o(rd), .wr_o(wr),
    .addr_o(addr), .wdata_o(wdata)
  );
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      mismatches++;
      final_report;
    end
  end
  // Log one error, then disturb the live values
  task log_err(input logic [15:0] c);
    @(posedge clk_i);
    #1;
    err_log = 1;
    code = c;
    cls = 3'(c % 5);
    tsec = 32'h1000_0000 + c;
    for (int k = 1; k <= 8; k++) f[k] = 16'(c + k);
    @(posedge clk_i);
    #1;
    err_log = 0;
    code = ~c;
    tsec = ~tsec;
    for (int k = 1; k <= 8; k++) f[k] = ~f[k];
  endtask
  task read_entry(input logic [15:0] c);
    mst.acc(0, `EHL_OFS_ENTRY_CODE, 0);
    chk("code", {16'h0000, c}, mst.q);
    chk("ack", 1, ack);
    chk("err", 0, mst.e);
    if (c == 16'h0000)
      return;
    mst.acc(0, `EHL_OFS_ENTRY_CLASS, 0);
    chk("class", 32'(c % 5), mst.q);
    mst.acc(0, `EHL_OFS_ENTRY_TIME, 0);
    chk("time", 32'h1000_0000 + c, mst.q);
    for (int k = 1; k <= 8; k++)
    begin
      mst.acc(0, 16'(`EHL_OFS_ENTRY_TIME + 2 * k), 0);
      chk("field", {16'h0000, 16'(c + k)}, mst.q);
    end
  endtask
  task t_history;
    for (int i = 1; i <= 12; i++) log_err(16'(16'h1100 + i));
    mst.acc(1, `EHL_OFS_READ_POINTER_REWIND, 1);
    for (int i = 3; i <= 12; i++) read_entry(16'(16'h1100 + i));
    read_entry(16'h0000);
    mst.acc(0, `EHL_OFS_POWER_ON_COUNT, 0);
    chk("power on", 32'h8765_4321, mst.q);
  endtask
  task t_controls;
    mst.acc(1, `EHL_OFS_READ_POINTER_REWIND, 0);
    read_entry(16'h0000);
    mst.acc(1, `EHL_OFS_HISTORY_CLEAR, 0);
    mst.acc(1, `EHL_OFS_READ_POINTER_REWIND, 1);
    read_entry(16'h1103);
    mst.acc(1, `EHL_OFS_ENTRY_CODE, 5);
    chk("ro write err", 1, mst.e);
    mst.acc(0, 16'h3c00, 0);
    chk("unmapped err", 1, mst.e);
  endtask
  // Reset in mid-run stands for a power cycle: history must survive
  task t_power_cycle;
    @(posedge clk_i);
    #1;
    reset_n_i = 0;
    repeat (2) @(posedge clk_i);
    #1;
    reset_n_i = 1;
    mst.acc(1, `EHL_OFS_READ_POINTER_REWIND, 1);
    read_entry(16'h1103);
    read_entry(16'h1104);
  endtask
  task t_clear;
    mst.acc(1, `EHL_OFS_HISTORY_CLEAR, 1);
    chk("clear ack", 1, ack);
    read_entry(16'h0000);
    mst.acc(0, `EHL_OFS_HISTORY_CLEAR, 0);
    chk("clear busy", 1, mst.q);
    for (int i = 0; i < 20 && mst.q !== 32'h0000_0000; i++)
      mst.acc(0, `EHL_OFS_HISTORY_CLEAR, 0);
    chk("clear done", 0, mst.q);
    mst.acc(1, `EHL_OFS_READ_POINTER_REWIND, 1);
    read_entry(16'h0000);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    #1;
    reset_n_i = 1;
    t_clear;
    t_history;
    t_controls;
    t_power_cycle;
    t_clear;
    final_report;
  end
endmodule
`default_nettype wire
